// File: rdc_map.svh
`ifndef RDC_MAP_SVH
`define RDC_MAP_SVH

// Register indices; the byte address is four times the index.
`define RDC_IDX_CTRL        10'h0c9
`define RDC_IDX_IRQ_EN      10'h0ca
`define RDC_IDX_IRQ_PRIO    10'h0cb
`define RDC_IDX_MONITOR     10'h0cc
`define RDC_IDX_EV_STATUS   10'h0cd
`define RDC_IDX_EV_MASK     10'h0ce
`define RDC_IDX_CAL         10'h0cf

// Control register fields.
`define RDC_CTRL_OFF_BIT    7
`define RDC_CTRL_RSVD_BIT   6
`define RDC_CTRL_LEVEL_BIT  4
`define RDC_CTRL_DROP_BIT   0
`define RDC_CTRL_RESET      8'h50

// Event bits of the sticky status and mask registers.
`define RDC_EV_DROP_IN      0
`define RDC_EV_DROP_OUT     1
`define RDC_EV_CAL_DONE     2
`define RDC_EV_COUNT        3

// Calibration register fields.
`define RDC_CAL_BUSY_BIT    0
`define RDC_CAL_DONE_BIT    1

// Timing.
`define RDC_CLK_MHZ         200
`define RDC_CAL_TIME_NS     1000
`define RDC_SETTLE_CYCLES   3

`endif

// File: rdc_pkg.sv
package rdc_pkg;

   typedef enum logic [1:0] {
      RDC_ST_SETTLE = 2'b00,
      RDC_ST_CAL    = 2'b01,
      RDC_ST_RUN    = 2'b10,
      RDC_ST_HOLD   = 2'b11
   } rdc_state_t;

   typedef struct packed {
      logic dropout;
      logic uncal_below_high;
   } rdc_ana_t;

   typedef struct packed {
      logic regulator_enable;
      logic level_high;
      logic monitor_high;
      logic cal_active;
      logic reset_hold;
   } rdc_ctl_t;

   typedef struct packed {
      logic       en;
      logic [7:0] data;
   } rdc_wr_t;

endpackage

// File: rdc_sync.sv
module rdc_sync
   import rdc_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   generate
      if (WIDTH < 1) begin : g_check
         $error("rdc_sync needs WIDTH of at least one");
      end
   endgenerate

   // The first stage feeds only the second stage.
   always_comb begin
      next_stage1   = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= next_stage1;
         sync_out <= next_sync_out;
      end
   end

endmodule

// File: rdc_event_reg.sv
module rdc_event_reg
   import rdc_pkg::*;
#(
   parameter int N = 3
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [N-1:0] ev_set,
   input  wire rdc_wr_t      clr_wr,
   input  wire rdc_wr_t      mask_wr,
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);

   logic [N-1:0] next_status;
   logic [N-1:0] next_mask;
   logic         next_irq;

   generate
      if (N < 1 || N > 8) begin : g_check
         $error("rdc_event_reg serves one to eight events");
      end
   endgenerate

   // A set in the same cycle as a write-one clear wins, so no event is lost.
   always_comb begin
      next_status = status;
      next_mask   = mask;
      if (clr_wr.en) begin
         next_status = status & ~clr_wr.data[N-1:0];
      end
      next_status = next_status | ev_set;
      if (mask_wr.en) begin
         next_mask = mask_wr.data[N-1:0];
      end
      next_irq = |(next_status & next_mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= '0;
         mask   <= '0;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         mask   <= next_mask;
         irq    <= next_irq;
      end
   end

endmodule

// File: rdc_regulator_ctrl.sv
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`include "rdc_map.svh"

// How it works
// - Regulator comes up enabled after any reset; software may switch it off.
// - Software selects the output level between the lower and higher voltage.
// - Dropout raises the regulator interrupt request only while its enable is set.
// - The dropout request has no latched pending flag; it follows the condition.
// - The readable dropout status clears by itself when dropout ends.
// - Regulator output calibration runs after every reset that does not take the reset hold.
// - High monitor threshold, non-power-on reset, low uncalibrated output hold reset.
// - Power-on reset returns the supply monitor to its low threshold.
// - Level select cleared picks the lower level, set picks the higher.
// - Regulator off bit written one disables the regulator, zero keeps it on.
// - Dropout status reads one in or near dropout, zero otherwise.
module rdc_regulator_ctrl
   import rdc_pkg::*;
#(
   parameter int CAL_CYCLES    = (`RDC_CAL_TIME_NS * `RDC_CLK_MHZ + 999) / 1000,
   parameter int SETTLE_CYCLES = `RDC_SETTLE_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        por_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire rdc_ana_t    ana_in,
   output rdc_ctl_t         ctl,
   output logic             dropout_irq_req,
   output logic             dropout_irq_priority,
   output logic             irq
);

   localparam int CNT_W = 16;

   generate
      if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_cal_check
         $error("CAL_CYCLES must lie between 1 and 65535");
      end
      if (SETTLE_CYCLES < 3 || SETTLE_CYCLES > 255) begin : g_settle_check
         $error("SETTLE_CYCLES must cover the two-stage synchronizer");
      end
   endgenerate

   function automatic logic idx_hit(input logic [31:0] addr, input logic [9:0] idx);
      idx_hit = (addr[11:2] == idx) && (addr[31:12] == 20'h00000);
   endfunction

   // Analog inputs are asynchronous to hclk.
   rdc_ana_t ana_sync;

   rdc_sync #(
      .WIDTH (2)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (ana_in),
      .sync_out (ana_sync)
   );

   // Bus and software-visible registers.
   logic        wr_pend;
   logic [31:0] wr_addr;
   logic        reg_off;
   logic        reg_rsvd;
   logic        reg_level;
   logic        irq_en;
   logic        irq_prio;
   logic        cal_done;
   logic        drop_q;
   logic        req_q;
   logic        next_wr_pend;
   logic [31:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic        next_reg_off;
   logic        next_reg_rsvd;
   logic        next_reg_level;
   logic        next_irq_en;
   logic        next_irq_prio;
   logic        next_cal_done;
   logic        next_drop_q;
   logic        next_req_q;
   logic        addr_phase;
   logic        rd_stall;
   rdc_wr_t     ev_clr_wr;
   rdc_wr_t     ev_mask_wr;
   logic [`RDC_EV_COUNT-1:0] ev_set;
   logic [`RDC_EV_COUNT-1:0] ev_status;
   logic [`RDC_EV_COUNT-1:0] ev_mask;

   // Sequencer state.
   rdc_state_t       state;
   rdc_state_t       next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             cal_finish;

   // Power-on domain: survives every reset but power-on.
   logic mon_high;
   logic hold;
   logic next_mon_high;
   logic next_hold;

   assign addr_phase = hsel && htrans[1] && hready;
   // A read right behind a write waits one cycle so it sees the new value.
   assign rd_stall   = wr_pend && hsel && htrans[1] && !hwrite;
   assign hreadyout  = !rd_stall;
   assign hresp      = 1'b0;

   always_comb begin
      next_wr_pend   = 1'b0;
      next_wr_addr   = wr_addr;
      next_hrdata    = hrdata;
      next_reg_off   = reg_off;
      next_reg_rsvd  = reg_rsvd;
      next_reg_level = reg_level;
      next_irq_en    = irq_en;
      next_irq_prio  = irq_prio;
      next_cal_done  = cal_done || cal_finish;
      ev_clr_wr      = '{en: 1'b0, data: hwdata[7:0]};
      ev_mask_wr     = '{en: 1'b0, data: hwdata[7:0]};
      if (wr_pend) begin
         if (idx_hit(wr_addr, `RDC_IDX_CTRL)) begin
            next_reg_off   = hwdata[`RDC_CTRL_OFF_BIT];
            next_reg_rsvd  = hwdata[`RDC_CTRL_RSVD_BIT];
            next_reg_level = hwdata[`RDC_CTRL_LEVEL_BIT];
         end
         if (idx_hit(wr_addr, `RDC_IDX_IRQ_EN)) begin
            next_irq_en = hwdata[0];
         end
         if (idx_hit(wr_addr, `RDC_IDX_IRQ_PRIO)) begin
            next_irq_prio = hwdata[0];
         end
         ev_clr_wr.en  = idx_hit(wr_addr, `RDC_IDX_EV_STATUS);
         ev_mask_wr.en = idx_hit(wr_addr, `RDC_IDX_EV_MASK);
      end
      if (addr_phase && hwrite) begin
         next_wr_pend = 1'b1;
         next_wr_addr = haddr;
      end
      if (addr_phase && !hwrite) begin
         next_hrdata = 32'h00000000;
         if (idx_hit(haddr, `RDC_IDX_CTRL)) begin
            next_hrdata[`RDC_CTRL_OFF_BIT]   = reg_off;
            next_hrdata[`RDC_CTRL_RSVD_BIT]  = reg_rsvd;
            next_hrdata[`RDC_CTRL_LEVEL_BIT] = reg_level;
            next_hrdata[`RDC_CTRL_DROP_BIT]  = ana_sync.dropout;
         end
         if (idx_hit(haddr, `RDC_IDX_IRQ_EN)) begin
            next_hrdata[0] = irq_en;
         end
         if (idx_hit(haddr, `RDC_IDX_IRQ_PRIO)) begin
            next_hrdata[0] = irq_prio;
         end
         if (idx_hit(haddr, `RDC_IDX_MONITOR)) begin
            next_hrdata[0] = mon_high;
         end
         if (idx_hit(haddr, `RDC_IDX_EV_STATUS)) begin
            next_hrdata[`RDC_EV_COUNT-1:0] = ev_status;
         end
         if (idx_hit(haddr, `RDC_IDX_EV_MASK)) begin
            next_hrdata[`RDC_EV_COUNT-1:0] = ev_mask;
         end
         if (idx_hit(haddr, `RDC_IDX_CAL)) begin
            next_hrdata[`RDC_CAL_BUSY_BIT] = (state == RDC_ST_CAL);
            next_hrdata[`RDC_CAL_DONE_BIT] = cal_done;
         end
      end
      // No pending flag: the request is the live condition gated by its enable.
      next_drop_q = ana_sync.dropout;
      next_req_q  = ana_sync.dropout && irq_en;
      ev_set = '0;
      ev_set[`RDC_EV_DROP_IN]  = ana_sync.dropout && !drop_q;
      ev_set[`RDC_EV_DROP_OUT] = !ana_sync.dropout && drop_q;
      ev_set[`RDC_EV_CAL_DONE] = cal_finish;
   end

   // Every register of this group returns to its value on any reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 32'h00000000;
         hrdata    <= 32'h00000000;
         reg_off   <= 1'b0;
         reg_rsvd  <= 1'b1;
         reg_level <= 1'b1;
         irq_en    <= 1'b0;
         irq_prio  <= 1'b0;
         cal_done  <= 1'b0;
         drop_q    <= 1'b0;
         req_q     <= 1'b0;
      end else begin
         wr_pend   <= next_wr_pend;
         wr_addr   <= next_wr_addr;
         hrdata    <= next_hrdata;
         reg_off   <= next_reg_off;
         reg_rsvd  <= next_reg_rsvd;
         reg_level <= next_reg_level;
         irq_en    <= next_irq_en;
         irq_prio  <= next_irq_prio;
         cal_done  <= next_cal_done;
         drop_q    <= next_drop_q;
         req_q     <= next_req_q;
      end
   end

   rdc_event_reg #(
      .N (`RDC_EV_COUNT)
   ) u_events (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ev_set  (ev_set),
      .clr_wr  (ev_clr_wr),
      .mask_wr (ev_mask_wr),
      .status  (ev_status),
      .mask    (ev_mask),
      .irq     (irq)
   );

   // After each release the synchronizer fills, then the threshold check runs.
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      cal_finish = 1'b0;
      case (state)
         RDC_ST_SETTLE: begin
            next_cnt = cnt + 16'h0001;
            if (cnt == CNT_W'(SETTLE_CYCLES - 1)) begin
               next_cnt = 16'h0000;
               if (hold || (mon_high && ana_sync.uncal_below_high)) begin
                  next_state = RDC_ST_HOLD;
               end else begin
                  next_state = RDC_ST_CAL;
               end
            end
         end
         RDC_ST_CAL: begin
            next_cnt = cnt + 16'h0001;
            if (cnt == CNT_W'(CAL_CYCLES - 1)) begin
               next_cnt   = 16'h0000;
               cal_finish = 1'b1;
               next_state = RDC_ST_RUN;
            end
         end
         RDC_ST_RUN: begin
            next_cnt = 16'h0000;
         end
         RDC_ST_HOLD: begin
            next_cnt = 16'h0000;
         end
         default: begin
            next_state = RDC_ST_SETTLE;
            next_cnt   = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= RDC_ST_SETTLE;
         cnt   <= 16'h0000;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Only power-on clears hold, and mon_high also clears on a software write, so a held reset cannot release itself.
   always_comb begin
      next_mon_high = mon_high;
      next_hold     = hold || (next_state == RDC_ST_HOLD);
      if (wr_pend && idx_hit(wr_addr, `RDC_IDX_MONITOR)) begin
         next_mon_high = hwdata[0];
      end
   end

   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         mon_high <= 1'b0;
         hold     <= 1'b0;
      end else begin
         mon_high <= next_mon_high;
         hold     <= next_hold;
      end
   end

   assign ctl.regulator_enable = !reg_off;
   assign ctl.level_high       = reg_level;
   assign ctl.monitor_high     = mon_high;
   assign ctl.cal_active       = (state == RDC_ST_CAL);
   assign ctl.reset_hold       = hold;
   assign dropout_irq_req      = req_q;
   assign dropout_irq_priority = irq_prio;

endmodule

// File: rdc_regulator_ctrl_chk.sv
module rdc_regulator_ctrl_chk
   import rdc_pkg::*;
#(
   parameter int CAL_CYCLES    = 200,
   parameter int SETTLE_CYCLES = 3
) (
   input wire logic     hclk,
   input wire logic     hresetn,
   input wire logic     por_n,
   input wire rdc_ana_t ana_in,
   input wire rdc_ctl_t ctl,
   input wire logic     dropout_irq_req
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] cal_len;
   logic [15:0] next_cal_len;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   always_comb begin
      next_cal_len = ctl.cal_active ? cal_len + 16'h0001 : 16'h0000;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cal_len <= 16'h0000;
      end else begin
         cal_len <= next_cal_len;
      end
   end

   sequence s_fresh_start;
      $rose(hresetn) && !ctl.monitor_high && !ctl.reset_hold;
   endsequence

   sequence s_cal_begins;
      ##[1:8] ctl.cal_active;
   endsequence

   up_enabled_a: assert property ($rose(hresetn) |-> ctl.regulator_enable && ctl.level_high)
      else $error("regulator not enabled after reset");
   rise_cause_a: assert property ($rose(dropout_irq_req) |-> $past(ana_in.dropout, 3))
      else $error("dropout request rose without dropout");
   no_latch_a: assert property (!$past(ana_in.dropout, 3) |-> !dropout_irq_req)
      else $error("dropout request held without dropout");
   cal_starts_a: assert property (s_fresh_start |-> s_cal_begins)
      else $error("calibration did not start after reset");
   cal_len_a: assert property ($fell(ctl.cal_active) |-> cal_len == 16'(CAL_CYCLES))
      else $error("calibration length wrong");
   hold_sticky_a: assert property (ctl.reset_hold |=> ctl.reset_hold || !por_n)
      else $error("reset hold left without power-on reset");
   hold_nocal_a: assert property (ctl.reset_hold |-> !ctl.cal_active)
      else $error("calibration active while held in reset");
   por_low_a: assert property ($rose(por_n) |-> !ctl.monitor_high && !ctl.reset_hold)
      else $error("power-on reset left monitor high");
endmodule

bind rdc_regulator_ctrl rdc_regulator_ctrl_chk #(
   .CAL_CYCLES   (CAL_CYCLES),
   .SETTLE_CYCLES(SETTLE_CYCLES)
) u_rdc_regulator_ctrl_chk (
   .hclk           (hclk),
   .hresetn        (hresetn),
   .por_n          (por_n),
   .ana_in         (ana_in),
   .ctl            (ctl),
   .dropout_irq_req(dropout_irq_req)
);

// File: rdc_regulator_ctrl_tb.sv
`include "rdc_map.svh"

`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end

module rdc_regulator_ctrl_tb
   import rdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int CAL = 4;

   logic        hclk;
   logic        hresetn;
   logic        por_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   rdc_ana_t    ana;
   rdc_ctl_t    ctl;
   logic        dropout_irq_req;
   logic        dropout_irq_priority;
   logic        irq;
   int          mismatches;
   int          tests_run;

   rdc_regulator_ctrl #(
      .CAL_CYCLES(CAL)
   ) u_rdc_regulator_ctrl (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .por_n               (por_n),
      .hsel                (hsel),
      .haddr               (haddr),
      .htrans              (htrans),
      .hwrite              (hwrite),
      .hsize               (hsize),
      .hwdata              (hwdata),
      .hready              (hreadyout),
      .hreadyout           (hreadyout),
      .hresp               (hresp),
      .hrdata              (hrdata),
      .ana_in              (ana),
      .ctl                 (ctl),
      .dropout_irq_req     (dropout_irq_req),
      .dropout_irq_priority(dropout_irq_priority),
      .irq                 (irq)
   );

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Expected control readback: only the off, reserved and level bits keep what was written.
   function automatic logic [31:0] ctrl_expect(input logic [7:0] wd, input logic drop);
      ctrl_expect = {24'h000000, wd & 8'hd0} | {31'h00000000, drop};
   endfunction

   // Ready is judged mid-cycle so the combinational answer is never raced at the edge.
   task automatic bus_wait(output logic [31:0] d);
      int   n;
      logic ok;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 40) begin
         @(negedge hclk);
         ok = (hreadyout === 1'b1);
         d = hrdata;
         @(posedge hclk);
         n++;
      end
      if (!ok) begin
         mismatches++;
         wrap_up();
      end
   endtask

   task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      logic [31:0] x;
      // Every transfer starts on a rising edge, so the request changes right after it.
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {20'h00000, idx, 2'b00};
      bus_wait(x);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      bus_wait(rd);
      `CHK("hresp", 1'b0, hresp)
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   task automatic reset_dut(input logic por);
      hresetn <= 1'b0;
      por_n <= ~por;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      por_n <= 1'b1;
   endtask

   task automatic cal_count(output int c);
      c = 0;
      repeat (20) begin
         @(negedge hclk);
         c += int'(ctl.cal_active === 1'b1);
      end
      @(posedge hclk);
   endtask

   initial begin
      logic [31:0] rd;
      logic [7:0]  d;
      int          c;
      hresetn = 1'b0;
      por_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      ana = '0;
      mismatches = 0;
      tests_run = 0;
      void'($urandom(32'h056c1fe5));
      reset_dut(1'b1);
      cal_count(c);
      `CHK("cal_cycles", CAL, c)
      bus(1'b0, `RDC_IDX_CTRL, 32'h0, rd);
      `CHK("ctrl_reset", ctrl_expect(`RDC_CTRL_RESET, 1'b0), rd)
      bus(1'b0, `RDC_IDX_MONITOR, 32'h0, rd);
      `CHK("monitor_default", 32'h00000000, rd)
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hd0 : (i == 1) ? 8'h40 : 8'($urandom);
         bus(1'b1, `RDC_IDX_CTRL, {24'h000000, d}, rd);
         bus(1'b0, `RDC_IDX_CTRL, 32'h0, rd);
         `CHK("ctrl_rw", ctrl_expect(d, 1'b0), rd)
         `CHK("reg_enable", ~d[7], ctl.regulator_enable)
         `CHK("level_high", d[4], ctl.level_high)
      end
      bus(1'b1, 10'h0d0, 32'hffffffff, rd);
      bus(1'b0, 10'h0d0, 32'h0, rd);
      `CHK("unmapped", 32'h00000000, rd)
      ana.dropout <= 1'b1;
      tick(5);
      `CHK("req_disabled", 1'b0, dropout_irq_req)
      bus(1'b0, `RDC_IDX_CTRL, 32'h0, rd);
      `CHK("drop_status", 1'b1, rd[0])
      bus(1'b1, `RDC_IDX_IRQ_EN, 32'h1, rd);
      bus(1'b1, `RDC_IDX_IRQ_PRIO, 32'h1, rd);
      tick(4);
      `CHK("req_enabled", 1'b1, dropout_irq_req)
      `CHK("priority", 1'b1, dropout_irq_priority)
      @(posedge hclk);
      ana.dropout <= 1'b0;
      tick(4);
      `CHK("req_follows", 1'b0, dropout_irq_req)
      bus(1'b0, `RDC_IDX_CTRL, 32'h0, rd);
      `CHK("drop_cleared", 1'b0, rd[0])
      bus(1'b0, `RDC_IDX_EV_STATUS, 32'h0, rd);
      `CHK("ev_status", 32'h00000007, rd)
      `CHK("irq_masked", 1'b0, irq)
      bus(1'b1, `RDC_IDX_EV_MASK, 32'h3, rd);
      tick(2);
      `CHK("irq_raised", 1'b1, irq)
      bus(1'b1, `RDC_IDX_EV_STATUS, 32'h3, rd);
      tick(2);
      `CHK("irq_cleared", 1'b0, irq)
      bus(1'b0, `RDC_IDX_EV_STATUS, 32'h0, rd);
      `CHK("ev_after_clr", 32'h00000004, rd)
      // The new dropout event lands on the same edge as the write-one clear of its bit.
      ana.dropout <= 1'b1;
      bus(1'b1, `RDC_IDX_EV_STATUS, 32'h1, rd);
      bus(1'b0, `RDC_IDX_EV_STATUS, 32'h0, rd);
      `CHK("set_beats_clr", 32'h00000005, rd)
      bus(1'b1, `RDC_IDX_MONITOR, 32'h1, rd);
      ana.uncal_below_high <= 1'b1;
      reset_dut(1'b0);
      cal_count(c);
      `CHK("held_no_cal", 0, c)
      `CHK("reset_hold", 1'b1, ctl.reset_hold)
      reset_dut(1'b1);
      cal_count(c);
      `CHK("por_cal", CAL, c)
      `CHK("monitor_low", 1'b0, ctl.monitor_high)
      `CHK("hold_gone", 1'b0, ctl.reset_hold)
      bus(1'b0, `RDC_IDX_CAL, 32'h0, rd);
      `CHK("cal_done", 32'h00000002, rd)
      wrap_up();
   end
endmodule
